// ===== src/emp_pkg.sv
// Constants shared by the external data memory port design
package emp_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_PAGE = 8'haa; // Page select
	localparam logic [7:0] IDX_CFG = 8'hb2; // Port configuration
	localparam logic [7:0] IDX_PTR_LO = 8'hc0; // Pointer low byte
	localparam logic [7:0] IDX_PTR_HI = 8'hc1; // Pointer high byte
	localparam logic [7:0] IDX_REG_A = 8'hc2; // First index register
	localparam logic [7:0] IDX_REG_B = 8'hc3; // Second index register
	localparam logic [7:0] IDX_CMD = 8'hc4; // Move command
	localparam logic [7:0] IDX_WDATA = 8'hc5; // Write data
	localparam logic [7:0] IDX_RDATA = 8'hc6; // Read data
	localparam logic [7:0] IDX_STAT = 8'hc7; // Status

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CFG_MUX_BIT = 4; // Mux select
	localparam int CFG_MODE_LSB = 2; // Memory mode field
	localparam int CFG_ALE_LSB = 0; // Latch pulse width
	localparam int CMD_GO_BIT = 0; // Start a move
	localparam int CMD_WE_BIT = 1; // Move is a write
	localparam int CMD_IDX_BIT = 2; // Paged indexed form
	localparam int CMD_SELB_BIT = 3; // Use second index register
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h03;

	// ----------------------------------------------------------------
	// Memory modes, variants and split boundary
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_ONCHIP = 2'h0;
	localparam logic [1:0] MODE_SPLIT_LATCH = 2'h1;
	localparam logic [1:0] MODE_SPLIT_PAGE = 2'h2;
	localparam logic [1:0] MODE_OFFCHIP = 2'h3;
	localparam int VAR_FULL = 0; // Both pin modes
	localparam int VAR_MID = 1; // Multiplexed only
	localparam int VAR_SMALL = 2; // No off-chip access
	localparam logic [15:0] SPLIT_LIMIT = 16'h1000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int STROBE_NS = 40; // Least strobe low time
	localparam int STROBE_CYC =
		(STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== src/emp_bus_cycle.sv
// Strobe and latch sequencer for one off-chip byte transfer
module emp_bus_cycle (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic we_i,
	input wire logic muxed_i,
	input wire logic [1:0] ale_w_i,
	output logic ale_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic addr_phase_o,
	output logic sample_o,
	output logic done_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ALE_HI = 3'h1,
		ST_ALE_LO = 3'h3,
		ST_STROBE = 3'h2,
		ST_HOLD = 3'h6
	} emp_seq_t;

	typedef struct packed {
		emp_seq_t st;
		logic [2:0] cnt; // Cycles left in the phase
		logic we;
		logic ale;
		logic rd_n;
		logic wr_n;
		logic addr_phase;
		logic sample;
		logic done;
	} emp_seq_s_t;

	emp_seq_s_t s_reg;
	emp_seq_s_t s_next;

	localparam logic [2:0] STB_LAST = 3'(emp_pkg::STROBE_CYC - 1);

	// Next state of the sequencer
	always_comb begin
		s_next = s_reg;
		s_next.sample = 1'b0;
		s_next.done = 1'b0;
		unique case (s_reg.st)
			ST_IDLE: begin
				if (start_i) begin
					s_next.we = we_i;
					s_next.addr_phase = 1'b1;
					if (muxed_i) begin
						// Latch pulse high then low, width+1 each [R16]
						s_next.st = ST_ALE_HI;
						s_next.ale = 1'b1;
						s_next.cnt = {1'b0, ale_w_i};
					end else begin
						// One setup cycle with address only
						s_next.st = ST_ALE_LO;
						s_next.cnt = 3'h0;
					end
				end
			end
			ST_ALE_HI: begin
				if (s_reg.cnt == 3'h0) begin
					s_next.st = ST_ALE_LO;
					s_next.ale = 1'b0;
					s_next.cnt = {1'b0, ale_w_i}; // [R16]
				end else begin
					s_next.cnt = s_reg.cnt - 3'h1;
				end
			end
			ST_ALE_LO: begin
				if (s_reg.cnt == 3'h0) begin
					// Exactly one strobe per byte [R17]
					s_next.st = ST_STROBE;
					s_next.addr_phase = 1'b0;
					s_next.rd_n = s_reg.we;
					s_next.wr_n = ~s_reg.we;
					s_next.cnt = STB_LAST;
				end else begin
					s_next.cnt = s_reg.cnt - 3'h1;
				end
			end
			ST_STROBE: begin
				if (s_reg.cnt == 3'h0) begin
					s_next.st = ST_HOLD;
					s_next.rd_n = 1'b1;
					s_next.wr_n = 1'b1;
					s_next.sample = ~s_reg.we;
				end else begin
					s_next.cnt = s_reg.cnt - 3'h1;
				end
			end
			ST_HOLD: begin
				s_next.st = ST_IDLE;
				s_next.done = 1'b1;
			end
			default: begin
				s_next.st = ST_IDLE;
				s_next.rd_n = 1'b1;
				s_next.wr_n = 1'b1;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '{st: ST_IDLE, cnt: 3'h0, we: 1'b0, ale: 1'b0,
				rd_n: 1'b1, wr_n: 1'b1, addr_phase: 1'b0,
				sample: 1'b0, done: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign ale_o = s_reg.ale;
	assign rd_n_o = s_reg.rd_n;
	assign wr_n_o = s_reg.wr_n;
	assign addr_phase_o = s_reg.addr_phase;
	assign sample_o = s_reg.sample;
	assign done_o = s_reg.done;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence ale_rise_s;
		start_i && s_reg.st == ST_IDLE && muxed_i && ale_w_i == 2'h1;
	endsequence

	ale_width_a: assert property ( // [R16]
		ale_rise_s |=> ale_o [*2] ##1 !ale_o [*2] ##1 !rd_n_o || !wr_n_o)
		else $error("latch pulse width wrong");

	one_strobe_a: assert property (!(rd_n_o == 1'b0 && wr_n_o == 1'b0)) // [R17]
		else $error("both strobes active");

endmodule // emp_bus_cycle

// ===== src/emp_ext_port.sv
// External data memory port: address generation, on-chip store, pins
//
// Register access over Wishbone was chosen for this implementation.

// Notes on behaviour
// [R01] Pointer form uses full 16-bit pointer
// [R02] Indexed form: page high, index low
// [R03] Pointer readable/writable as two bytes
// [R04] Pins owned only during off-chip move
// [R05] Input pins undriven during a move
// [R06] Output drive mode never touched here
// [R07] Software parks port latches idle high
// [R08] Software skips strobe and latch pins
// [R09] Pin mapping per multiplex mode
// [R10] Software configures in five ordered steps
// [R11] Four memory modes for moves
// [R12] Page register resets zero, selects page
// [R13] Variant parameter limits pin modes
// [R14] Mux select 0 multiplexed, 1 not
// [R15] Memory mode field decode, 4 kB split
// [R16] Latch pulse high/low width 1..4
// [R17] Strobes active low, one per byte
module emp_ext_port #(
	parameter int VARIANT = emp_pkg::VAR_FULL,
	parameter int ONCHIP_BYTES = 4096
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] addr_hi_latch_i,
	input wire logic [7:0] p2_latch_i,
	input wire logic [7:0] p3_latch_i,
	input wire logic [7:0] p4_latch_i,
	input wire logic [2:0] ctl_latch_i,
	input wire logic [7:0] p3_in_i,
	input wire logic [7:0] p4_in_i,
	output logic [7:0] p2_out_o,
	output logic [7:0] p2_oe_n_o,
	output logic [7:0] p3_out_o,
	output logic [7:0] p3_oe_n_o,
	output logic [7:0] p4_out_o,
	output logic [7:0] p4_oe_n_o,
	output logic ale_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic pins_owned_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] page; // Page select
		logic mux_sel;
		logic [1:0] mode;
		logic [1:0] ale_w;
		logic [7:0] ptr_hi;
		logic [7:0] ptr_lo;
		logic [7:0] idx_a;
		logic [7:0] idx_b;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic busy; // Move in progress
		logic ext; // Move goes off-chip
		logic we;
		logic phase; // On-chip read data phase
		logic go; // Start pulse to sequencer
		logic [15:0] addr; // Effective address
		logic ack;
		logic [31:0] dat;
		logic [7:0] sync3a;
		logic [7:0] sync3b;
		logic [7:0] sync4a;
		logic [7:0] sync4b;
		logic own;
		logic [7:0] p2;
		logic [7:0] p3;
		logic [7:0] p4;
		logic [7:0] p2_oe_n;
		logic [7:0] p3_oe_n;
		logic [7:0] p4_oe_n;
		logic ale;
		logic rd_n;
		logic wr_n;
	} emp_state_t;

	emp_state_t s_reg;
	emp_state_t s_next;

	// On-chip data store
	logic [7:0] onchip_mem [ONCHIP_BYTES];
	logic [7:0] onchip_q;

	// Sequencer outputs
	logic seq_ale;
	logic seq_rd_n;
	logic seq_wr_n;
	logic seq_addr_phase;
	logic seq_sample;
	logic seq_done;

	// Decoded bus fields
	logic bus_req;
	logic [7:0] reg_idx;
	logic muxed_eff;

	// Register select for an aligned word
	function automatic logic hit(input logic [9:0] adr,
		input logic [7:0] idx);
		hit = adr[9:2] == idx && adr[1:0] == 2'h0;
	endfunction

	// Whether a move address lands off-chip [R11] [R15]
	function automatic logic goes_off(input logic [1:0] mode,
		input logic [15:0] a);
		if (VARIANT == emp_pkg::VAR_SMALL) begin
			goes_off = 1'b0; // [R13]
		end else begin
			unique case (mode)
				emp_pkg::MODE_ONCHIP: goes_off = 1'b0;
				emp_pkg::MODE_OFFCHIP: goes_off = 1'b1;
				default: goes_off = a >= emp_pkg::SPLIT_LIMIT;
			endcase
		end
	endfunction

	assign bus_req = wb_cyc_i && wb_stb_i && !s_reg.ack;
	assign reg_idx = wb_adr_i[9:2];
	// Mid and small variants only multiplex; bit 4 selects it otherwise [R13] [R14]
	assign muxed_eff = (VARIANT != emp_pkg::VAR_FULL) || !s_reg.mux_sel;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	emp_bus_cycle u_seq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(s_reg.go),
		.we_i(s_reg.we),
		.muxed_i(muxed_eff),
		.ale_w_i(s_reg.ale_w),
		.ale_o(seq_ale),
		.rd_n_o(seq_rd_n),
		.wr_n_o(seq_wr_n),
		.addr_phase_o(seq_addr_phase),
		.sample_o(seq_sample),
		.done_o(seq_done)
	);

	// ----------------------------------------------------------------
	// Next state: bus slave, move control, pin drive
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] hi;
		logic [15:0] a;
		logic [7:0] din;
		hi = 8'h00;
		a = 16'h0000;
		din = 8'h00;
		s_next = s_reg;
		s_next.go = 1'b0;
		s_next.ack = bus_req;
		// Pin synchronisers, second stage only is read
		s_next.sync3a = p3_in_i;
		s_next.sync3b = s_reg.sync3a;
		s_next.sync4a = p4_in_i;
		s_next.sync4b = s_reg.sync4a;
		// Register reads
		if (bus_req) begin
			s_next.dat = 32'h0000_0000;
			if (hit(wb_adr_i, emp_pkg::IDX_PAGE)) begin
				s_next.dat[7:0] = s_reg.page;
			end else if (hit(wb_adr_i, emp_pkg::IDX_CFG)) begin
				s_next.dat[7:0] = {3'h0, s_reg.mux_sel, s_reg.mode,
					s_reg.ale_w};
			end else if (hit(wb_adr_i, emp_pkg::IDX_PTR_LO)) begin
				s_next.dat[7:0] = s_reg.ptr_lo; // [R03]
			end else if (hit(wb_adr_i, emp_pkg::IDX_PTR_HI)) begin
				s_next.dat[7:0] = s_reg.ptr_hi; // [R03]
			end else if (hit(wb_adr_i, emp_pkg::IDX_REG_A)) begin
				s_next.dat[7:0] = s_reg.idx_a;
			end else if (hit(wb_adr_i, emp_pkg::IDX_REG_B)) begin
				s_next.dat[7:0] = s_reg.idx_b;
			end else if (hit(wb_adr_i, emp_pkg::IDX_WDATA)) begin
				s_next.dat[7:0] = s_reg.wdata;
			end else if (hit(wb_adr_i, emp_pkg::IDX_RDATA)) begin
				s_next.dat[7:0] = s_reg.rdata;
			end else if (hit(wb_adr_i, emp_pkg::IDX_STAT)) begin
				s_next.dat[7:0] = {6'h00, s_reg.ext, s_reg.busy};
			end
		end
		// Register writes, low byte lane only
		if (bus_req && wb_we_i && wb_sel_i[0]) begin
			if (hit(wb_adr_i, emp_pkg::IDX_PAGE)) begin
				s_next.page = wb_dat_i[7:0]; // [R12]
			end else if (hit(wb_adr_i, emp_pkg::IDX_CFG)) begin
				s_next.mux_sel = wb_dat_i[emp_pkg::CFG_MUX_BIT]; // [R14]
				s_next.mode = wb_dat_i[emp_pkg::CFG_MODE_LSB +: 2];
				s_next.ale_w = wb_dat_i[emp_pkg::CFG_ALE_LSB +: 2];
			end else if (hit(wb_adr_i, emp_pkg::IDX_PTR_LO)) begin
				s_next.ptr_lo = wb_dat_i[7:0]; // [R03]
			end else if (hit(wb_adr_i, emp_pkg::IDX_PTR_HI)) begin
				s_next.ptr_hi = wb_dat_i[7:0]; // [R03]
			end else if (hit(wb_adr_i, emp_pkg::IDX_REG_A)) begin
				s_next.idx_a = wb_dat_i[7:0];
			end else if (hit(wb_adr_i, emp_pkg::IDX_REG_B)) begin
				s_next.idx_b = wb_dat_i[7:0];
			end else if (hit(wb_adr_i, emp_pkg::IDX_WDATA)) begin
				s_next.wdata = wb_dat_i[7:0];
			end else if (hit(wb_adr_i, emp_pkg::IDX_CMD) && !s_reg.busy
				&& wb_dat_i[emp_pkg::CMD_GO_BIT]) begin
				// Form the effective address
				if (wb_dat_i[emp_pkg::CMD_IDX_BIT]) begin
					// Split without bank takes high byte from latch when that lands off-chip, else from the page [R15]
					hi = (s_reg.mode == emp_pkg::MODE_SPLIT_LATCH &&
						goes_off(s_reg.mode, {addr_hi_latch_i, 8'h00}))
						? addr_hi_latch_i : s_reg.page;
					a = {hi, wb_dat_i[emp_pkg::CMD_SELB_BIT]
						? s_reg.idx_b : s_reg.idx_a}; // [R02] [R12]
				end else begin
					a = {s_reg.ptr_hi, s_reg.ptr_lo}; // [R01]
				end
				s_next.addr = a;
				s_next.we = wb_dat_i[emp_pkg::CMD_WE_BIT];
				s_next.busy = 1'b1;
				s_next.phase = 1'b0;
				s_next.ext = goes_off(s_reg.mode, a); // [R11]
				s_next.go = goes_off(s_reg.mode, a);
			end
		end
		// On-chip move: access, then take read data
		if (s_reg.busy && !s_reg.ext) begin
			s_next.phase = 1'b1;
			if (s_reg.phase) begin
				s_next.busy = 1'b0;
				if (!s_reg.we) begin
					s_next.rdata = onchip_q;
				end
			end
		end
		// Off-chip move: capture data, finish on done
		din = (VARIANT == emp_pkg::VAR_FULL) ? s_reg.sync4b : s_reg.sync3b;
		if (seq_sample) begin
			s_next.rdata = din;
		end
		if (seq_done) begin
			s_next.busy = 1'b0;
			s_next.ext = 1'b0;
		end
		// Pin drive: latch values unless a move owns the pins [R04]
		s_next.own = s_reg.busy && s_reg.ext && !seq_done;
		s_next.p2 = p2_latch_i;
		s_next.p3 = p3_latch_i;
		s_next.p4 = p4_latch_i;
		s_next.p2_oe_n = 8'h00;
		s_next.p3_oe_n = 8'h00;
		s_next.p4_oe_n = 8'h00;
		s_next.ale = ctl_latch_i[0];
		s_next.rd_n = ctl_latch_i[1];
		s_next.wr_n = ctl_latch_i[2];
		if (s_next.own) begin
			s_next.rd_n = seq_rd_n; // [R17]
			s_next.wr_n = seq_wr_n; // [R17]
			s_next.ale = muxed_eff && seq_ale;
			if (VARIANT == emp_pkg::VAR_MID) begin
				// Shared lines on port 3, high address on port 2 [R09]
				s_next.p2 = s_reg.addr[15:8];
				s_next.p3 = seq_addr_phase ? s_reg.addr[7:0] : s_reg.wdata;
				s_next.p3_oe_n = (!seq_addr_phase && !s_reg.we)
					? 8'hff : 8'h00; // [R05]
			end else if (muxed_eff) begin
				// Shared lines on port 4, high address on port 3 [R09]
				s_next.p3 = s_reg.addr[15:8];
				s_next.p4 = seq_addr_phase ? s_reg.addr[7:0] : s_reg.wdata;
				s_next.p4_oe_n = (!seq_addr_phase && !s_reg.we)
					? 8'hff : 8'h00; // [R05]
			end else begin
				// Data port 4, low port 3, high port 2 [R09]
				s_next.p2 = s_reg.addr[15:8];
				s_next.p3 = s_reg.addr[7:0];
				s_next.p4 = s_reg.wdata;
				s_next.p4_oe_n = s_reg.we ? 8'h00 : 8'hff; // [R05]
			end
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
			s_reg.page <= emp_pkg::PAGE_RST; // [R12]
			s_reg.mux_sel <= emp_pkg::CFG_RST[emp_pkg::CFG_MUX_BIT];
			s_reg.mode <= emp_pkg::CFG_RST[emp_pkg::CFG_MODE_LSB +: 2];
			s_reg.ale_w <= emp_pkg::CFG_RST[emp_pkg::CFG_ALE_LSB +: 2];
			s_reg.rd_n <= 1'b1;
			s_reg.wr_n <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// On-chip store, aliased to 4096 bytes by address bits 11:0 [R15]
	always_ff @(posedge clk_i) begin
		if (s_reg.busy && !s_reg.ext && !s_reg.phase && s_reg.we) begin
			onchip_mem[s_reg.addr[11:0]] <= s_reg.wdata;
		end
		onchip_q <= onchip_mem[s_reg.addr[11:0]];
	end

	// ----------------------------------------------------------------
	// Outputs, all from flip-flops; drive mode is never an output [R06]
	// ----------------------------------------------------------------
	assign wb_dat_o = s_reg.dat;
	assign wb_ack_o = s_reg.ack;
	assign p2_out_o = s_reg.p2;
	assign p3_out_o = s_reg.p3;
	assign p4_out_o = s_reg.p4;
	assign p2_oe_n_o = s_reg.p2_oe_n;
	assign p3_oe_n_o = s_reg.p3_oe_n;
	assign p4_oe_n_o = s_reg.p4_oe_n;
	assign ale_o = s_reg.ale;
	assign rd_n_o = s_reg.rd_n;
	assign wr_n_o = s_reg.wr_n;
	assign pins_owned_o = s_reg.own;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	page_reset_a: assert property (disable iff (1'b0) // [R12]
		rst_i |=> s_reg.page == 8'h00 && s_reg.ale_w == 2'h3)
		else $error("reset values wrong");

	sequence cmd_ptr_s;
		bus_req && wb_we_i && wb_sel_i[0] && !s_reg.busy
			&& hit(wb_adr_i, emp_pkg::IDX_CMD) && wb_dat_i[0]
			&& !wb_dat_i[2];
	endsequence

	ptr_addr_a: assert property ( // [R01]
		cmd_ptr_s |=> s_reg.addr == {$past(s_reg.ptr_hi), $past(s_reg.ptr_lo)})
		else $error("pointer address wrong");

	idx_addr_a: assert property ( // [R02]
		bus_req && wb_we_i && wb_sel_i[0] && !s_reg.busy && wb_dat_i[0]
			&& hit(wb_adr_i, emp_pkg::IDX_CMD) && wb_dat_i[2]
			&& s_reg.mode != emp_pkg::MODE_SPLIT_LATCH
		|=> s_reg.addr[15:8] == $past(s_reg.page))
		else $error("paged address wrong");

	pins_idle_a: assert property ( // [R04]
		!s_reg.busy |=> !pins_owned_o)
		else $error("pins owned without a move");

	read_undriven_a: assert property ( // [R05]
		pins_owned_o && !rd_n_o && VARIANT == emp_pkg::VAR_FULL
		|-> p4_oe_n_o == 8'hff)
		else $error("data driven during read");

	strobe_excl_a: assert property ( // [R17]
		pins_owned_o |-> !(rd_n_o == 1'b0 && wr_n_o == 1'b0))
		else $error("both strobes active");

	ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

	onchip_mode_a: assert property ( // [R11]
		s_reg.mode == emp_pkg::MODE_ONCHIP && s_reg.busy |-> !s_reg.ext)
		else $error("off-chip move in on-chip mode");

	split_low_a: assert property ( // [R15]
		s_reg.busy && s_reg.mode == emp_pkg::MODE_SPLIT_PAGE
			&& s_reg.addr < emp_pkg::SPLIT_LIMIT |-> !s_reg.ext)
		else $error("low split address sent off-chip");

endmodule // emp_ext_port

// ===== verif/emp_sram_model.sv
// Behavioural off-chip byte memory hung on the port pins
module emp_sram_model (
	input wire logic clk_i,
	input wire logic muxed_i,
	input wire logic [7:0] p2_out_i,
	input wire logic [7:0] p3_out_i,
	input wire logic [7:0] p4_out_i,
	input wire logic ale_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	output logic [7:0] p4_in_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535]; // Byte storage
	logic [15:0] lat_q = 16'h0000; // Address caught while latch is high
	logic [7:0] last_q = 8'h00; // Last byte put on the data lines
	logic [7:0] wd_q = 8'h00; // Data seen while write strobe is low
	logic wr_q = 1'b1; // Write strobe one edge ago
	logic [15:0] addr; // Address in use
	// Address from latch or from the separate address ports
	assign addr = muxed_i ? lat_q : {p2_out_i, p3_out_i};
	// Drive only under read strobe; released lines show the inverse
	assign p4_in_o = !rd_n_i ? mem[addr] : ~last_q;
	// ----------------------------------------------------------------
	// Latch, capture and commit
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (ale_i) lat_q <= {p3_out_i, p4_out_i};
		if (!rd_n_i) last_q <= mem[addr];
		if (!wr_n_i) wd_q <= p4_out_i;
		// Byte lands as the write strobe rises
		if (wr_n_i && !wr_q) mem[addr] <= wd_q;
		wr_q <= wr_n_i;
	end
endmodule // emp_sram_model

// ===== verif/external_data_memory_port_tb_top.sv
// Self-checking bench for the external data memory port
`define CHK(a, b) begin \
	comparisons++; \
	if ((a) !== (b)) begin \
		errors++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
	end \
end
module external_data_memory_port_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [3:0] sel = 4'h1, lanes = 4'h1; // Lanes of the next request
	logic [7:0] hi_latch = 8'h00; // High-address port latch value
	logic [31:0] wdat = 32'h0000_0000, rdat;
	logic ack, ale, rd_n, wr_n, owned;
	logic muxed = 1'b1; // Tells the memory how to find its address
	logic [7:0] p2o, p3o, p4o, p2e, p3e, p4e, p4i, p3i, q;
	logic rd_q = 1'b1, wr_q = 1'b1; // Strobes one edge ago
	int errors = 0;
	int comparisons = 0;
	int ale_n, rd_f, wr_f, oe_ok, own_n; // Pin activity of one move
	assign p3i = ~p3o; // Port 3 never read back here
	emp_ext_port uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.addr_hi_latch_i(hi_latch), .p2_latch_i(8'hff),
		.p3_latch_i(8'hff), .p4_latch_i(8'hff),
		.ctl_latch_i(3'b110), // Strobes parked high, latch low
		.p3_in_i(p3i), .p4_in_i(p4i), .p2_out_o(p2o), .p2_oe_n_o(p2e),
		.p3_out_o(p3o), .p3_oe_n_o(p3e), .p4_out_o(p4o),
		.p4_oe_n_o(p4e), .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n),
		.pins_owned_o(owned));
	emp_sram_model m (.clk_i(clk_i), .muxed_i(muxed), .p2_out_i(p2o),
		.p3_out_i(p3o), .p4_out_i(p4o), .ale_i(ale), .rd_n_i(rd_n),
		.wr_n_i(wr_n), .p4_in_o(p4i));
	// Free-running system clock
	initial forever #5 clk_i = ~clk_i;
	// Count latch cycles, strobe falls and drive state per move
	always @(posedge clk_i) begin
		if (owned) own_n++;
		if (ale) ale_n++;
		if (!rd_n && rd_q) rd_f++;
		if (!wr_n && wr_q) wr_f++;
		if (!rd_n && p4e !== 8'hff) oe_ok = 0;
		rd_q <= rd_n;
		wr_q <= wr_n;
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One classic cycle; read byte lands in q
	task automatic wb(input logic w, input logic [7:0] idx,
		input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= lanes;
		adr <= {idx, 2'b00};
		wdat <= {24'h00_0000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			errors++;
			print_verdict();
		end
	endtask
	// Launch a move and poll until busy clears
	task automatic move(input logic [7:0] cmd);
		int n;
		ale_n = 0;
		rd_f = 0;
		wr_f = 0;
		oe_ok = 1;
		own_n = 0;
		wb(1'b1, emp_pkg::IDX_CMD, cmd);
		n = 0;
		do begin
			wb(1'b0, emp_pkg::IDX_STAT, 8'h00);
			n++;
		end while (q[0] !== 1'b0 && n < 40);
		if (q[0] !== 1'b0) begin
			errors++;
			print_verdict();
		end
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		`CHK(owned, 1'b0);
		`CHK({rd_n, wr_n}, 2'b11);
		wb(1'b0, emp_pkg::IDX_PAGE, 8'h00);
		`CHK(q, emp_pkg::PAGE_RST);
		wb(1'b0, emp_pkg::IDX_CFG, 8'h00);
		`CHK(q, emp_pkg::CFG_RST);
		wb(1'b0, 8'h00, 8'h00);
		`CHK(q, 8'h00); // Unmapped place reads zero
		$display("test reset done");
	endtask
	task automatic t_pointer();
		wb(1'b1, emp_pkg::IDX_PTR_HI, 8'h12);
		wb(1'b1, emp_pkg::IDX_PTR_LO, 8'h34);
		lanes = 4'h0; // Lane 0 off: write must be ignored
		wb(1'b1, emp_pkg::IDX_PTR_LO, 8'hff);
		lanes = 4'h1;
		wb(1'b0, emp_pkg::IDX_PTR_HI, 8'h00);
		`CHK(q, 8'h12);
		wb(1'b0, emp_pkg::IDX_PTR_LO, 8'h00);
		`CHK(q, 8'h34);
		$display("test pointer done");
	endtask
	// Multiplexed pins, off-chip only, latch width code 01
	task automatic t_mux_ptr();
		muxed = 1'b1;
		wb(1'b1, emp_pkg::IDX_CFG, 8'h0d); // Steps in order
		wb(1'b1, emp_pkg::IDX_WDATA, 8'ha5);
		move(8'h03);
		`CHK(ale_n, 2);
		`CHK(wr_f, 1);
		`CHK(rd_f, 0);
		`CHK(m.mem[16'h1234], 8'ha5);
		move(8'h01);
		`CHK(rd_f, 1);
		`CHK(oe_ok, 1);
		wb(1'b0, emp_pkg::IDX_RDATA, 8'h00);
		`CHK(q, 8'ha5);
		`CHK(owned, 1'b0);
		`CHK({p4o, p4e}, 16'hff00);
		`CHK({p2e, p3e}, 16'h0000);
		$display("test multiplexed done");
	endtask
	// Separate pins, paged form through both index registers
	task automatic t_paged();
		muxed = 1'b0;
		wb(1'b1, emp_pkg::IDX_CFG, 8'h1c);
		wb(1'b1, emp_pkg::IDX_PAGE, 8'h12);
		wb(1'b1, emp_pkg::IDX_REG_A, 8'h56);
		wb(1'b1, emp_pkg::IDX_WDATA, 8'h3c);
		move(8'h07);
		`CHK(m.mem[16'h1256], 8'h3c);
		m.mem[16'h1257] = 8'h77;
		wb(1'b1, emp_pkg::IDX_REG_B, 8'h57);
		move(8'h0d);
		`CHK(rd_f, 1);
		`CHK(oe_ok, 1);
		wb(1'b0, emp_pkg::IDX_RDATA, 8'h00);
		`CHK(q, 8'h77);
		// Split without bank: paged high byte from the port latch
		wb(1'b1, emp_pkg::IDX_CFG, 8'h14);
		hi_latch <= 8'h34;
		wb(1'b1, emp_pkg::IDX_WDATA, 8'h5a);
		move(8'h07);
		`CHK(m.mem[16'h3456], 8'h5a);
		$display("test paged done");
	endtask
	// Every memory mode against an address below and above 4 kB
	task automatic t_modes();
		wb(1'b1, emp_pkg::IDX_CFG, 8'h10);
		wb(1'b1, emp_pkg::IDX_WDATA, 8'h99);
		move(8'h03);
		move(8'h01);
		wb(1'b0, emp_pkg::IDX_RDATA, 8'h00);
		`CHK(q, 8'h99);
		for (int md = 0; md < 4; md++) begin
			for (int hi = 0; hi < 2; hi++) begin
				wb(1'b1, emp_pkg::IDX_CFG, {4'h1, md[1:0], 2'b00});
				wb(1'b1, emp_pkg::IDX_PTR_HI, hi ? 8'h20 : 8'h00);
				move(8'h01);
				`CHK(own_n > 0, md == 3 || (hi == 1 && md != 0));
			end
		end
		$display("test modes done");
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_pointer();
		t_mux_ptr();
		t_paged();
		t_modes();
		print_verdict();
	end
endmodule // external_data_memory_port_tb_top
